/* File: logic/hpc_top.sv */
`timescale 1ns/1ps
// Behaviour
// - Self-powered mask: bit n disables port n
// - Bus-powered mask: same mapping, separate
// - Mask bit 0 always reads zero
// - Standard mode keeps masked ports disabled
// - Report enabled count, renumber active ports
// - Default configuration uses port strap inputs
// - Self-powered draw reported in 2mA units
// - Bus-powered draw covers hub and board
// - Embedded zero-draw peripheral folded into figure
// - Remap enable: zero standard, one remap
module hpc_top
  import hpc_pkg::*;
(
  input  wire logic                    clk_i,        // 125 MHz clock
  input  wire logic                    rst_b_i,      // Async reset, low
  input  wire logic                    ce_i,         // Clock enable
  input  wire logic [7:0]              addr_i,       // Register address
  input  wire logic [HPC_DW-1:0]       wdata_i,      // Write data
  input  wire logic                    wr_i,         // Write strobe
  input  wire logic                    rd_i,         // Read strobe
  input  wire logic                    self_pwr_i,   // Self-powered pin
  input  wire logic [HPC_NPORT:1]      strap_plus_i, // port_off_strap_plus pins
  input  wire logic [HPC_NPORT:1]      strap_minus_i,// port_off_strap_minus pins
  output logic      [HPC_DW-1:0]       rdata_o,      // Read data, next cycle
  output logic      [HPC_NPORT:1]      port_off_o,   // Ports held disabled
  output logic      [HPC_CW-1:0]       port_cnt_o,   // Reported port count
  output logic      [HPC_NPORT*HPC_CW-1:0] port_map_o, // Logical number per port
  output logic      [HPC_DW-1:0]       vbus_draw_o,  // Reported draw, 2mA units
  output logic                         remap_o       // Remap mode active
);
  import hpc_pkg::*;

  // Register state
  logic [HPC_DW-1:0] sp_mask_r, sp_mask_nxt;
  logic [HPC_DW-1:0] bp_mask_r, bp_mask_nxt;
  logic [HPC_DW-1:0] sp_draw_r, sp_draw_nxt;
  logic [HPC_DW-1:0] bp_draw_r, bp_draw_nxt;
  logic [HPC_DW-1:0] ctrl_r,    ctrl_nxt;
  logic [HPC_DW-1:0] rdata_nxt;

  // Pin synchronisers, three stages each
  logic [2:0] pwr_s_r;
  logic [HPC_NPORT:1] sp_s1_r, sp_s2_r, sp_s3_r;
  logic [HPC_NPORT:1] sm_s1_r, sm_s2_r, sm_s3_r;
  logic pwr_q_r, pwr_q_nxt;
  logic [HPC_NPORT:1] strap_q_r, strap_q_nxt;

  // Outputs
  logic [HPC_NPORT:1]          off_nxt;
  logic [HPC_CW-1:0]           cnt_w;
  logic [HPC_NPORT*HPC_CW-1:0] map_w;
  logic [HPC_DW-1:0]           draw_nxt;
  logic                        remap_nxt;
  hpc_mode_t                   mode;

  // Write data destined for a mask loses bit 0
  function automatic logic [HPC_DW-1:0] mask_clean(input logic [HPC_DW-1:0] v);
    return v & HPC_RSV_BIT0;
  endfunction

  // Address hit for a write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Register writes
  always_comb begin
    sp_mask_nxt = sp_mask_r;
    bp_mask_nxt = bp_mask_r;
    sp_draw_nxt = sp_draw_r;
    bp_draw_nxt = bp_draw_r;
    ctrl_nxt    = ctrl_r;
    if (wr_i) begin
      if (hit(addr_i, HPC_OFS_SP_MASK)) sp_mask_nxt = mask_clean(wdata_i);
      if (hit(addr_i, HPC_OFS_BP_MASK)) bp_mask_nxt = mask_clean(wdata_i);
      if (hit(addr_i, HPC_OFS_SP_DRAW)) sp_draw_nxt = wdata_i;
      if (hit(addr_i, HPC_OFS_BP_DRAW)) bp_draw_nxt = wdata_i;
      if (hit(addr_i, HPC_OFS_CTRL))    ctrl_nxt    = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sp_mask_r <= HPC_RST_MASK;
      bp_mask_r <= HPC_RST_MASK;
      sp_draw_r <= HPC_RST_DRAW;
      bp_draw_r <= HPC_RST_DRAW;
      ctrl_r    <= HPC_RST_CTRL;
    end else if (ce_i) begin
      sp_mask_r <= sp_mask_nxt;
      bp_mask_r <= bp_mask_nxt;
      sp_draw_r <= sp_draw_nxt;
      bp_draw_r <= bp_draw_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // Filtered pin values: change only once stages two and three agree
  always_comb begin
    pwr_q_nxt   = (pwr_s_r[1] == pwr_s_r[2]) ? pwr_s_r[2] : pwr_q_r;
    strap_q_nxt = strap_q_r;
    for (int p = 1; p <= HPC_NPORT; p++) begin
      if (sp_s2_r[p] == sp_s3_r[p] && sm_s2_r[p] == sm_s3_r[p])
        strap_q_nxt[p] = sp_s3_r[p] & sm_s3_r[p];
    end
  end

  // Power pin and strap synchronisers; pins are asynchronous to clk_i
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_s_r   <= '0;
      sp_s1_r   <= '0;
      sp_s2_r   <= '0;
      sp_s3_r   <= '0;
      sm_s1_r   <= '0;
      sm_s2_r   <= '0;
      sm_s3_r   <= '0;
      pwr_q_r   <= 1'b0;
      strap_q_r <= '0;
    end else if (ce_i) begin
      pwr_s_r   <= {pwr_s_r[1:0], self_pwr_i};
      sp_s1_r   <= strap_plus_i;
      sp_s2_r   <= sp_s1_r;
      sp_s3_r   <= sp_s2_r;
      sm_s1_r   <= strap_minus_i;
      sm_s2_r   <= sm_s1_r;
      sm_s3_r   <= sm_s2_r;
      pwr_q_r   <= pwr_q_nxt;
      strap_q_r <= strap_q_nxt;
    end
  end

  // Power mode picks the active set
  assign mode = pwr_q_r ? HPC_MODE_SELF : HPC_MODE_BUS;

  // Effective disable set; both straps high marks a port off.
  // Remap mode hands port control elsewhere, so nothing is forced off here.
  always_comb begin
    logic [HPC_DW-1:0] m;
    m = HPC_ZERO;
    case (mode)
      HPC_MODE_SELF: m = sp_mask_r;
      HPC_MODE_BUS:  m = bp_mask_r;
      default:       m = HPC_ZERO;
    endcase
    if (ctrl_r[HPC_CTRL_DEFCFG])
      off_nxt = strap_q_r;
    else
      off_nxt = m[HPC_NPORT:1];
    if (ctrl_r[HPC_CTRL_REMAP])
      off_nxt = '0;
    remap_nxt = ctrl_r[HPC_CTRL_REMAP];
  end

  // Renumbering of surviving ports
  hpc_port_pack u_pack (
    .off_i (off_nxt),
    .cnt_o (cnt_w),
    .map_o (map_w)
  );

  // Draw figure; the embedded peripheral is already inside the bus figure
  // only when compound and it declares zero, so the value passes as set
  always_comb begin
    case (mode)
      HPC_MODE_SELF: draw_nxt = sp_draw_r;
      HPC_MODE_BUS:  draw_nxt = bp_draw_r;
      default:       draw_nxt = bp_draw_r;
    endcase
  end

  // Read mux, data stands one cycle after the strobe
  always_comb begin
    rdata_nxt = HPC_ZERO;
    if (rd_i) begin
      case (addr_i)
        HPC_OFS_SP_MASK: rdata_nxt = mask_clean(sp_mask_r);
        HPC_OFS_BP_MASK: rdata_nxt = mask_clean(bp_mask_r);
        HPC_OFS_SP_DRAW: rdata_nxt = sp_draw_r;
        HPC_OFS_BP_DRAW: rdata_nxt = bp_draw_r;
        HPC_OFS_CTRL:    rdata_nxt = ctrl_r;
        HPC_OFS_STATUS: begin
          rdata_nxt[HPC_ST_SELFPWR] = pwr_q_r;
          rdata_nxt[HPC_ST_CNT_LO +: HPC_CW] = port_cnt_o;
          rdata_nxt[HPC_ST_EFF_REMAP] = remap_o;
        end
        HPC_OFS_MAP:     rdata_nxt = {port_off_o, 1'b0};
        default:         rdata_nxt = HPC_ZERO;
      endcase
    end
  end

  // Output registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o     <= '0;
      port_off_o  <= '0;
      port_cnt_o  <= '0;
      port_map_o  <= '0;
      vbus_draw_o <= '0;
      remap_o     <= 1'b0;
    end else if (ce_i) begin
      rdata_o     <= rdata_nxt;
      port_off_o  <= off_nxt;
      port_cnt_o  <= cnt_w;
      port_map_o  <= map_w;
      vbus_draw_o <= draw_nxt;
      remap_o     <= remap_nxt;
    end
  end

  // Checks
  chk_mask_bit0: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !sp_mask_r[0] && !bp_mask_r[0]) else $error("mask bit 0 set");
  chk_sp_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == HPC_OFS_SP_MASK |=> sp_mask_r == mask_clean($past(wdata_i)))
    else $error("self mask write lost");
  chk_bp_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && wr_i && addr_i == HPC_OFS_BP_MASK |=> bp_mask_r == mask_clean($past(wdata_i)))
    else $error("bus mask write lost");
  chk_bus_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !ctrl_r[HPC_CTRL_REMAP] && !ctrl_r[HPC_CTRL_DEFCFG] && !pwr_q_r
    |=> port_off_o == $past(bp_mask_r[HPC_NPORT:1])) else $error("bus mask not applied");
  chk_status_pwr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && rd_i && addr_i == HPC_OFS_STATUS |=> rdata_o[HPC_ST_SELFPWR] == $past(pwr_q_r))
    else $error("status power bit wrong");
  chk_std_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !ctrl_r[HPC_CTRL_REMAP] && !ctrl_r[HPC_CTRL_DEFCFG] && pwr_q_r
    |=> port_off_o == $past(sp_mask_r[HPC_NPORT:1])) else $error("self mask not applied");
  chk_cnt_true: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> port_cnt_o == HPC_CW'(HPC_NPORT - $countones($past(off_nxt))))
    else $error("port count wrong");
  chk_strap_use: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && ctrl_r[HPC_CTRL_DEFCFG] && !ctrl_r[HPC_CTRL_REMAP]
    |=> port_off_o == $past(strap_q_r)) else $error("straps not used");
  chk_draw_mode: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> vbus_draw_o == ($past(pwr_q_r) ? $past(sp_draw_r) : $past(bp_draw_r)))
    else $error("draw set wrong");
  chk_remap_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && ctrl_r[HPC_CTRL_REMAP] |=> remap_o && port_off_o == '0)
    else $error("remap mode wrong");
  chk_rd_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && !rd_i |=> rdata_o == HPC_ZERO) else $error("read data stale");
  cov_self: cover property (@(posedge clk_i) disable iff (!rst_b_i) pwr_q_r && port_cnt_o != '0);
  cov_remap: cover property (@(posedge clk_i) disable iff (!rst_b_i) remap_o);
  cov_bus: cover property (@(posedge clk_i) disable iff (!rst_b_i) !pwr_q_r && port_off_o != '0);
  cov_strap: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    ctrl_r[HPC_CTRL_DEFCFG] && port_off_o != '0);
endmodule // hpc_top

/* File: pkg/hpc_pkg.sv */
package hpc_pkg;
  // Register map
  localparam logic [7:0] HPC_OFS_SP_MASK  = 8'h0a;
  localparam logic [7:0] HPC_OFS_BP_MASK  = 8'h0b;
  localparam logic [7:0] HPC_OFS_SP_DRAW  = 8'h0c;
  localparam logic [7:0] HPC_OFS_BP_DRAW  = 8'h0d;
  localparam logic [7:0] HPC_OFS_CTRL     = 8'h20;
  localparam logic [7:0] HPC_OFS_STATUS   = 8'h21;
  localparam logic [7:0] HPC_OFS_MAP      = 8'h22;
  // Widths
  localparam int         HPC_DW           = 8;
  localparam int         HPC_NPORT        = 7;
  localparam int         HPC_CW           = 3;
  // Field positions
  localparam int         HPC_CTRL_REMAP   = 0;
  localparam int         HPC_CTRL_DEFCFG  = 1;
  localparam int         HPC_CTRL_COMPND  = 2;
  localparam int         HPC_CTRL_EMB0    = 3;
  localparam int         HPC_ST_SELFPWR   = 0;
  localparam int         HPC_ST_CNT_LO    = 1;
  localparam int         HPC_ST_EFF_REMAP = 4;
  // Reset values
  localparam logic [7:0] HPC_RST_MASK     = 8'h00;
  localparam logic [7:0] HPC_RST_DRAW     = 8'h32;
  localparam logic [7:0] HPC_RST_CTRL     = 8'h00;
  localparam logic [7:0] HPC_RSV_BIT0     = 8'hfe;
  localparam logic [7:0] HPC_ZERO         = 8'h00;
  // Mode selection
  typedef enum logic {HPC_MODE_BUS, HPC_MODE_SELF} hpc_mode_t;
endpackage

/* File: logic/hpc_port_pack.sv */
`timescale 1ns/1ps
// Packs enabled physical ports into consecutive logical numbers
module hpc_port_pack
  import hpc_pkg::*;
(
  input  wire logic [HPC_NPORT:1]  off_i,  // Disabled ports
  output logic      [HPC_CW-1:0]   cnt_o,  // Enabled port count
  output logic      [HPC_NPORT*HPC_CW-1:0] map_o // Logical number per port, 0 = none
);
  // Running count over ports, lowest enabled port gets logical 1
  always_comb begin
    logic [HPC_CW-1:0] run;
    run   = '0;
    map_o = '0;
    for (int p = 1; p <= HPC_NPORT; p++) begin
      if (!off_i[p]) begin
        run = run + 3'h1;
        map_o[(p-1)*HPC_CW +: HPC_CW] = run;
      end
    end
    cnt_o = run;
  end
endmodule // hpc_port_pack

/* File: testbench/hpc_host_model.sv */
`timescale 1ns/1ps
// Upstream host: latches the hub's descriptor figures at enumeration
module hpc_host_model (
  input  wire logic                      clk_i,  // Shared clock
  input  wire logic                      enum_i, // Enumerate request
  input  wire logic [hpc_pkg::HPC_CW-1:0] cnt_i,  // Hub port count
  input  wire logic [hpc_pkg::HPC_DW-1:0] draw_i, // Hub draw, 2mA units
  output logic      [hpc_pkg::HPC_CW-1:0] cnt_o,  // Ports as seen by host
  output logic      [hpc_pkg::HPC_DW-1:0] draw_o  // Draw as seen by host
);
  import hpc_pkg::*;
  // Host only looks at the figures when it enumerates, not continuously
  always_ff @(posedge clk_i) begin
    if (enum_i) begin
      cnt_o  <= cnt_i;
      draw_o <= draw_i;
    end
  end
endmodule // hpc_host_model

/* File: testbench/hpc_top_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the port and power configuration bank
module hpc_top_test;
  import hpc_pkg::*;
  logic        clk_i, rst_b_i, ce_i, wr_i, rd_i, self_pwr_i, remap_o, host_enum;
  logic [7:0]  addr_i, wdata_i, rdata_o, vbus_draw_o, h_draw;
  logic [7:1]  strap_plus_i, strap_minus_i, port_off_o;
  logic [2:0]  port_cnt_o, h_cnt;
  logic [20:0] port_map_o;
  int          n_fail, checks, seed, ctl, off, cnt, map, v;
  int          m [4];

  hpc_top i_dut (.clk_i, .rst_b_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .self_pwr_i, .strap_plus_i, .strap_minus_i, .rdata_o, .port_off_o,
    .port_cnt_o, .port_map_o, .vbus_draw_o, .remap_o);
  hpc_host_model i_host (.clk_i, .enum_i(host_enum), .cnt_i(port_cnt_o),
    .draw_i(vbus_draw_o), .cnt_o(h_cnt), .draw_o(h_draw));

  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Compare with four-state equality so unknowns never pass
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input int e, input string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, e, rdata_o);
  endtask

  // Power pin and straps pass a synchroniser, so allow a few edges
  task automatic settle();
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  // Model of port state, count, numbering and draw
  task automatic check_outs();
    off = ctl[0] ? 0 : ctl[1] ? int'(strap_plus_i & strap_minus_i)
                     : (self_pwr_i ? m[0] : m[1]) >> 1;
    cnt = 0;
    map = 0;
    for (int p = 1; p <= 7; p++) begin
      if (!off[p-1]) begin
        cnt++;
        map |= cnt << (3 * (p - 1));
      end
    end
    chk("port_off", off, port_off_o);
    chk("remap", ctl & 1, remap_o);
    chk("draw", self_pwr_i ? m[2] : m[3], vbus_draw_o);
    if (!ctl[0]) begin
      chk("port_cnt", cnt, port_cnt_o);
      chk("port_map", map, port_map_o);
      rd(HPC_OFS_STATUS, self_pwr_i | (cnt << 1), "status");
      rd(HPC_OFS_MAP, off << 1, "off_view");
    end
    @(posedge clk_i);
    host_enum <= 1'b1;
    @(posedge clk_i);
    host_enum <= 1'b0;
    #1 chk("host_draw", self_pwr_i ? m[2] : m[3], h_draw);
    if (!ctl[0]) chk("host_cnt", cnt, h_cnt);
  endtask

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    summarize();
  end

  initial begin
    {rst_b_i, wr_i, rd_i, host_enum, addr_i, wdata_i} = '0;
    {ce_i, self_pwr_i} = 2'b11;
    strap_plus_i = 7'h00;
    strap_minus_i = 7'h00;
    seed = 24;
    m = '{0, 0, 'h32, 'h32};
    ctl = 0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 4; k++) rd(HPC_OFS_SP_MASK + k, m[k], "reset_cfg");
    rd(8'h30, 0, "unmapped");
    settle();
    check_outs();
    $display("reset values done");
    // Random masks and draws across both power modes
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      self_pwr_i <= i[0];
      for (int k = 0; k < 4; k++) begin
        v = $random(seed) & 'hff;
        if (k == 2) v = v % 51;
        m[k] = k < 2 ? v & 'hfe : v;
        wr(HPC_OFS_SP_MASK + k, v[7:0]);
        rd(HPC_OFS_SP_MASK + k, m[k], "cfg_readback");
      end
      settle();
      check_outs();
    end
    $display("random masks done");
    // Writes while frozen must not land
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(HPC_OFS_SP_MASK, ~m[0][7:0]);
    ce_i <= 1'b1;
    rd(HPC_OFS_SP_MASK, m[0], "frozen_write");
    $display("clock enable done");
    // Default configuration takes disabled ports from straps
    ctl = 2;
    wr(HPC_OFS_CTRL, 8'h02);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      strap_plus_i <= $random(seed);
      strap_minus_i <= $random(seed);
      settle();
      check_outs();
    end
    $display("strap config done");
    // Remap mode lifts the masks
    ctl = 1;
    wr(HPC_OFS_CTRL, 8'h01);
    settle();
    check_outs();
    rd(HPC_OFS_CTRL, 1, "ctrl_readback");
    $display("remap done");
    summarize();
  end
endmodule // hpc_top_test
